// file: rtl/adivc_regs.svh
// Register offsets, field positions, reset values and timing constants
// Assumes a 32-bit APB slave, byte addresses, one aligned word per register
//
// Behaviour
// - Quotient is numerator over denominator; inputs single or redundant pairs.
// - Window option adds window output with high, low and hysteresis settings.
// - Window comparator keeps two states; output 0 outside, 1 inside.
// - Outside enters inside when low < q < high - hysteresis, else stays.
// - Inside stays while low + hysteresis < q < high.
// - Threshold option: under goes over when q strictly exceeds threshold.
// - Threshold returns over to under only below threshold minus hysteresis.
// - Warning option adds output with own threshold, hysteresis, direction select.
// - Warning output is 1 when over, 0 when under.
// - Warning enters over above threshold plus hysteresis, leaves below threshold.
// - Converter sample rate selectable; 50 and 60 per second included.
// - Current mode: limits 2,5..3,9 mA and 20,1..23 mA; outside raises diagnostic.
// - Voltage mode: minimum 0 V, maximum 10,05..11,5 V; above raises diagnostic.
// - On a math error the quotient is forced to 0 or 200000.
// - Analog output option exposes raw measurements.
// - Error output option signals an error detected by the block.
// - Math error is 1 on zero divisor, open cable, overloads or mismatch.
// - Redundant mismatch: deviation above limit for longer than timeout seconds.
`ifndef ADIVC_REGS_SVH
`define ADIVC_REGS_SVH

// Register byte offsets
`define ADIVC_OFS_CTRL      8'h00
`define ADIVC_OFS_RATE      8'h04
`define ADIVC_OFS_WIN_HI    8'h08
`define ADIVC_OFS_WIN_LO    8'h0C
`define ADIVC_OFS_WIN_HYST  8'h10
`define ADIVC_OFS_THR       8'h14
`define ADIVC_OFS_THR_HYST  8'h18
`define ADIVC_OFS_WARN_THR  8'h1C
`define ADIVC_OFS_WARN_HYST 8'h20
`define ADIVC_OFS_CUR_MIN   8'h24
`define ADIVC_OFS_CUR_MAX   8'h28
`define ADIVC_OFS_VOLT_MAX  8'h2C
`define ADIVC_OFS_DEV_MAX   8'h30
`define ADIVC_OFS_TMO_SEC   8'h34
`define ADIVC_OFS_STATUS    8'h38
`define ADIVC_OFS_QUOT      8'h3C

// Control fields
`define ADIVC_CTRL_WIN_EN   0
`define ADIVC_CTRL_THR_EN   1
`define ADIVC_CTRL_WARN_EN  2
`define ADIVC_CTRL_WARN_LOW 3
`define ADIVC_CTRL_VOLT     4
`define ADIVC_CTRL_REDUND   5
`define ADIVC_CTRL_SAT_HI   6
`define ADIVC_CTRL_ANA_EN   7
`define ADIVC_CTRL_ERR_EN   8
`define ADIVC_CTRL_W        9
`define ADIVC_CTRL_RST      9'h000

// Status fields
`define ADIVC_ST_WIN      0
`define ADIVC_ST_THR      1
`define ADIVC_ST_WARN     2
`define ADIVC_ST_MATH     3
`define ADIVC_ST_RANGE    4
`define ADIVC_ST_DIV0     5
`define ADIVC_ST_MISM     6
`define ADIVC_ST_OVL      7

// Limits in uA and mV, clamped on write
`define ADIVC_CUR_MIN_LO  16'h09C4
`define ADIVC_CUR_MIN_HI  16'h0F3C
`define ADIVC_CUR_MAX_LO  16'h4E84
`define ADIVC_CUR_MAX_HI  16'h59D8
`define ADIVC_VOLT_MAX_LO 16'h2742
`define ADIVC_VOLT_MAX_HI 16'h2CEC
`define ADIVC_CUR_MIN_RST  16'h0E10
`define ADIVC_CUR_MAX_RST  16'h5014
`define ADIVC_VOLT_MAX_RST 16'h2742

// Saturation values and quotient fraction bits
`define ADIVC_SAT_HI      32'h00030D40
`define ADIVC_SAT_LO      32'h00000000
`define ADIVC_QFRAC       8

// Sample rates per second, index 0..3
`define ADIVC_SPS0        32'h00000032
`define ADIVC_SPS1        32'h0000003C
`define ADIVC_SPS2        32'h00000064
`define ADIVC_SPS3        32'h00000190
`define ADIVC_RATE_RST    2'h0

// Mismatch timebase in seconds and system clock rate in Hz
`define ADIVC_SEC_UNIT    32'h00000001
`define ADIVC_CLK_HZ      50000000

`endif

// file: rtl/adivc_pkg.sv
// Types shared by the quotient comparator block
// Assumes adivc_regs.svh supplies the numeric constants
package adivc_pkg;
  typedef logic [31:0] adivc_word_t;
  typedef logic [15:0] adivc_meas_t;
  typedef enum logic {outside_band_state, inside_band_state} adivc_win_t;
  typedef enum logic {under_thr_state, over_thr_state} adivc_thr_t;
endpackage

// file: rtl/adivc_top.sv
// Quotient comparators with range diagnostics, mismatch check and APB registers
// Assumes measurements in uA or mV, synchronous to i_sys_clk, with a valid pulse
`include "adivc_regs.svh"

module adivc_top #(
  parameter int unsigned CLK_HZ = `ADIVC_CLK_HZ
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [7:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  input  wire logic [3:0]           i_pstrb,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  input  wire adivc_pkg::adivc_meas_t i_num,
  input  wire adivc_pkg::adivc_meas_t i_num_red,
  input  wire adivc_pkg::adivc_meas_t i_den,
  input  wire adivc_pkg::adivc_meas_t i_den_red,
  input  wire logic                 i_sample_vld,
  input  wire logic                 i_pwr_ovl,
  input  wire logic                 i_in_ovl,
  output logic                      o_conv_start,
  output logic                      o_window_in_range_out,
  output logic                      o_thr_out,
  output logic                      o_warn_out,
  output logic                      o_math_err,
  output logic                      o_error_out,
  output adivc_pkg::adivc_word_t    o_quotient,
  output adivc_pkg::adivc_meas_t    o_analog_num,
  output adivc_pkg::adivc_meas_t    o_analog_den
);
  import adivc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Byte-lane merge of an APB write
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Clamp a limit into its permitted range
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // Widen to signed so threshold plus or minus hysteresis never wraps
  function automatic logic signed [33:0] ext(input logic [31:0] v);
    return signed'({2'b00, v});
  endfunction

  // Absolute difference of two measurements
  function automatic logic [15:0] adiff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction

  // Conversion period in cycles for a rate index
  function automatic logic [31:0] rate_cycles(input logic [1:0] sel);
    logic [31:0] sps;
    unique case (sel)
      2'h0: sps = `ADIVC_SPS0;
      2'h1: sps = `ADIVC_SPS1;
      2'h2: sps = `ADIVC_SPS2;
      2'h3: sps = `ADIVC_SPS3;
    endcase
    return CLK_HZ / sps;
  endfunction

  localparam logic [31:0] SEC_CYCLES = CLK_HZ * `ADIVC_SEC_UNIT;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [`ADIVC_CTRL_W-1:0] ctrl_r;
  logic [1:0]               rate_r;
  logic [31:0]              win_hi_r, win_lo_r, win_hyst_r;
  logic [31:0]              thr_r, thr_hyst_r, warn_thr_r, warn_hyst_r;
  logic [15:0]              cur_min_r, cur_max_r, volt_max_r, dev_max_r;
  logic [7:0]               tmo_sec_r;
  adivc_win_t               win_st_r;
  adivc_thr_t               thr_st_r, warn_st_r;
  logic [31:0]              quot_r;
  logic                     math_r, range_r, div0_r, ovl_r, dev_r;
  logic [31:0]              conv_cnt_r, sec_cnt_r;
  logic [7:0]               mism_sec_r;

  logic        acc, wr_en, rd_en, hit;
  logic [31:0] rd_data;
  logic [31:0] wm_c;
  logic [15:0] num_c, den_c;
  logic [23:0] raw_quot;
  logic        range_c, div0_c, mism_c, math_c, dev_c;
  logic [31:0] quot_c;
  logic signed [33:0] q_s;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: one wait-free access phase, pready from a flop

  assign acc   = i_psel & i_penable & o_pready;
  assign wr_en = acc & i_pwrite & hit;
  assign rd_en = i_psel & ~i_penable & ~i_pwrite;
  // Write data merged over the addressed register's present value
  assign wm_c  = wmerge(rd_data, i_pwdata, i_pstrb);

  // Read multiplexer and address hit
  always_comb begin
    hit     = 1'b1;
    rd_data = 32'h00000000;
    unique case (i_paddr)
      `ADIVC_OFS_CTRL:      rd_data = {23'h000000, ctrl_r};
      `ADIVC_OFS_RATE:      rd_data = {30'h00000000, rate_r};
      `ADIVC_OFS_WIN_HI:    rd_data = win_hi_r;
      `ADIVC_OFS_WIN_LO:    rd_data = win_lo_r;
      `ADIVC_OFS_WIN_HYST:  rd_data = win_hyst_r;
      `ADIVC_OFS_THR:       rd_data = thr_r;
      `ADIVC_OFS_THR_HYST:  rd_data = thr_hyst_r;
      `ADIVC_OFS_WARN_THR:  rd_data = warn_thr_r;
      `ADIVC_OFS_WARN_HYST: rd_data = warn_hyst_r;
      `ADIVC_OFS_CUR_MIN:   rd_data = {16'h0000, cur_min_r};
      `ADIVC_OFS_CUR_MAX:   rd_data = {16'h0000, cur_max_r};
      `ADIVC_OFS_VOLT_MAX:  rd_data = {16'h0000, volt_max_r};
      `ADIVC_OFS_DEV_MAX:   rd_data = {16'h0000, dev_max_r};
      `ADIVC_OFS_TMO_SEC:   rd_data = {24'h000000, tmo_sec_r};
      `ADIVC_OFS_STATUS:    rd_data = {24'h000000, ovl_r, mism_c, div0_r, range_r, math_r,
                                       warn_st_r == over_thr_state,
                                       thr_st_r == over_thr_state,
                                       win_st_r == inside_band_state};
      `ADIVC_OFS_QUOT:      rd_data = quot_r;
      default:              hit = 1'b0;
    endcase
  end

  // Answer flops: ready in the first access cycle, error on unmapped
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~hit;
      o_prdata  <= rd_en ? rd_data : 32'h00000000;
    end
  end

  // Configuration registers; current and voltage limits clamped into range
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_r      <= `ADIVC_CTRL_RST;
      rate_r      <= `ADIVC_RATE_RST;
      win_hi_r    <= 32'h00000000;
      win_lo_r    <= 32'h00000000;
      win_hyst_r  <= 32'h00000000;
      thr_r       <= 32'h00000000;
      thr_hyst_r  <= 32'h00000000;
      warn_thr_r  <= 32'h00000000;
      warn_hyst_r <= 32'h00000000;
      cur_min_r   <= `ADIVC_CUR_MIN_RST;
      cur_max_r   <= `ADIVC_CUR_MAX_RST;
      volt_max_r  <= `ADIVC_VOLT_MAX_RST;
      dev_max_r   <= 16'h0000;
      tmo_sec_r   <= 8'h00;
    end else if (wr_en) begin
      unique case (i_paddr)
        `ADIVC_OFS_CTRL:
          ctrl_r <= wm_c[`ADIVC_CTRL_W-1:0];
        `ADIVC_OFS_RATE:
          rate_r <= wm_c[1:0];
        `ADIVC_OFS_WIN_HI:    win_hi_r    <= wmerge(win_hi_r, i_pwdata, i_pstrb);
        `ADIVC_OFS_WIN_LO:    win_lo_r    <= wmerge(win_lo_r, i_pwdata, i_pstrb);
        `ADIVC_OFS_WIN_HYST:  win_hyst_r  <= wmerge(win_hyst_r, i_pwdata, i_pstrb);
        `ADIVC_OFS_THR:       thr_r       <= wmerge(thr_r, i_pwdata, i_pstrb);
        `ADIVC_OFS_THR_HYST:  thr_hyst_r  <= wmerge(thr_hyst_r, i_pwdata, i_pstrb);
        `ADIVC_OFS_WARN_THR:  warn_thr_r  <= wmerge(warn_thr_r, i_pwdata, i_pstrb);
        `ADIVC_OFS_WARN_HYST: warn_hyst_r <= wmerge(warn_hyst_r, i_pwdata, i_pstrb);
        `ADIVC_OFS_CUR_MIN:
          cur_min_r <= clamp16(wm_c[15:0], `ADIVC_CUR_MIN_LO, `ADIVC_CUR_MIN_HI);
        `ADIVC_OFS_CUR_MAX:
          cur_max_r <= clamp16(wm_c[15:0], `ADIVC_CUR_MAX_LO, `ADIVC_CUR_MAX_HI);
        `ADIVC_OFS_VOLT_MAX:
          volt_max_r <= clamp16(wm_c[15:0], `ADIVC_VOLT_MAX_LO, `ADIVC_VOLT_MAX_HI);
        `ADIVC_OFS_DEV_MAX:
          dev_max_r <= wm_c[15:0];
        `ADIVC_OFS_TMO_SEC:
          tmo_sec_r <= wm_c[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion start pacing at the selected rate

  // One start pulse per conversion period
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      conv_cnt_r   <= 32'h00000000;
      o_conv_start <= 1'b0;
    end else if (conv_cnt_r >= rate_cycles(rate_r) - 32'h00000001) begin
      conv_cnt_r   <= 32'h00000000;
      o_conv_start <= 1'b1;
    end else begin
      conv_cnt_r   <= conv_cnt_r + 32'h00000001;
      o_conv_start <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement diagnostics and quotient

  // Range check, zero divisor and deviation of the redundant pairs
  always_comb begin
    num_c   = i_num;
    den_c   = i_den;
    div0_c  = (den_c == 16'h0000);
    if (ctrl_r[`ADIVC_CTRL_VOLT]) begin
      range_c = (i_num > volt_max_r) || (i_den > volt_max_r);
      if (ctrl_r[`ADIVC_CTRL_REDUND]) begin
        range_c = range_c || (i_num_red > volt_max_r) || (i_den_red > volt_max_r);
      end
    end else begin
      range_c = (i_num < cur_min_r) || (i_num > cur_max_r) ||
                (i_den < cur_min_r) || (i_den > cur_max_r);
      if (ctrl_r[`ADIVC_CTRL_REDUND]) begin
        range_c = range_c || (i_num_red < cur_min_r) || (i_num_red > cur_max_r) ||
                  (i_den_red < cur_min_r) || (i_den_red > cur_max_r);
      end
    end
    dev_c = ctrl_r[`ADIVC_CTRL_REDUND] &&
            ((adiff(i_num, i_num_red) > dev_max_r) ||
             (adiff(i_den, i_den_red) > dev_max_r));
  end

  // Fixed-point quotient of the primary channels
  assign raw_quot = div0_c ? 24'h000000 : ({num_c, 8'h00} / {8'h00, den_c});
  assign mism_c   = dev_r && (mism_sec_r > tmo_sec_r);
  assign math_c   = div0_c | range_c | i_pwr_ovl | i_in_ovl | mism_c;
  assign quot_c   = math_c ? (ctrl_r[`ADIVC_CTRL_SAT_HI] ? `ADIVC_SAT_HI : `ADIVC_SAT_LO)
                           : {8'h00, raw_quot};
  assign q_s      = ext(quot_c);

  // Deviation persistence measured in whole seconds
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dev_r      <= 1'b0;
      sec_cnt_r  <= 32'h00000000;
      mism_sec_r <= 8'h00;
    end else begin
      if (i_sample_vld) begin
        dev_r <= dev_c;
      end
      if (!dev_r) begin
        sec_cnt_r  <= 32'h00000000;
        mism_sec_r <= 8'h00;
      end else if (sec_cnt_r >= SEC_CYCLES - 32'h00000001) begin
        sec_cnt_r  <= 32'h00000000;
        mism_sec_r <= (mism_sec_r == 8'hFF) ? mism_sec_r : mism_sec_r + 8'h01;
      end else begin
        sec_cnt_r <= sec_cnt_r + 32'h00000001;
      end
    end
  end

  // Diagnostics and quotient captured per sample
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      quot_r  <= 32'h00000000;
      math_r  <= 1'b0;
      range_r <= 1'b0;
      div0_r  <= 1'b0;
      ovl_r   <= 1'b0;
    end else if (i_sample_vld) begin
      quot_r  <= quot_c;
      math_r  <= math_c;
      range_r <= range_c;
      div0_r  <= div0_c;
      ovl_r   <= i_pwr_ovl | i_in_ovl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparators, stepped once per sample

  // Window comparator with hysteresis on both edges
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      win_st_r <= outside_band_state;
    end else if (i_sample_vld) begin
      unique case (win_st_r)
        outside_band_state:
          if (q_s > ext(win_lo_r) && q_s < ext(win_hi_r) - ext(win_hyst_r)) begin
            win_st_r <= inside_band_state;
          end
        inside_band_state:
          if (!(q_s < ext(win_hi_r) && q_s > ext(win_lo_r) + ext(win_hyst_r))) begin
            win_st_r <= outside_band_state;
          end
      endcase
    end
  end

  // Threshold comparator, hysteresis on the falling side
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      thr_st_r <= under_thr_state;
    end else if (i_sample_vld) begin
      unique case (thr_st_r)
        under_thr_state:
          if (q_s > ext(thr_r)) begin
            thr_st_r <= over_thr_state;
          end
        over_thr_state:
          if (q_s < ext(thr_r) - ext(thr_hyst_r)) begin
            thr_st_r <= under_thr_state;
          end
      endcase
    end
  end

  // Warning comparator; lower-limit mode mirrors the direction
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      warn_st_r <= under_thr_state;
    end else if (i_sample_vld) begin
      unique case (warn_st_r)
        under_thr_state:
          if (ctrl_r[`ADIVC_CTRL_WARN_LOW] ? (q_s < ext(warn_thr_r) - ext(warn_hyst_r))
                                           : (q_s > ext(warn_thr_r) + ext(warn_hyst_r))) begin
            warn_st_r <= over_thr_state;
          end
        over_thr_state:
          if (ctrl_r[`ADIVC_CTRL_WARN_LOW] ? (q_s > ext(warn_thr_r))
                                           : (q_s < ext(warn_thr_r))) begin
            warn_st_r <= under_thr_state;
          end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flops, gated by their options

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_window_in_range_out <= 1'b0;
      o_thr_out             <= 1'b0;
      o_warn_out            <= 1'b0;
      o_math_err            <= 1'b0;
      o_error_out           <= 1'b0;
      o_quotient            <= 32'h00000000;
      o_analog_num          <= 16'h0000;
      o_analog_den          <= 16'h0000;
    end else begin
      o_window_in_range_out <= ctrl_r[`ADIVC_CTRL_WIN_EN] &&
                               (win_st_r == inside_band_state);
      o_thr_out             <= ctrl_r[`ADIVC_CTRL_THR_EN] && !ctrl_r[`ADIVC_CTRL_WIN_EN] &&
                               (thr_st_r == over_thr_state);
      o_warn_out            <= ctrl_r[`ADIVC_CTRL_WARN_EN] &&
                               (warn_st_r == over_thr_state);
      o_math_err            <= math_r;
      o_error_out           <= ctrl_r[`ADIVC_CTRL_ERR_EN] && math_r;
      o_quotient            <= quot_r;
      o_analog_num          <= ctrl_r[`ADIVC_CTRL_ANA_EN] ? i_num : 16'h0000;
      o_analog_den          <= ctrl_r[`ADIVC_CTRL_ANA_EN] ? i_den : 16'h0000;
    end
  end

endmodule

// file: test/adivc_assertions.sv
// Port checker for the quotient comparator top
// Assumes it is bound to adivc_top and sees only its ports
module adivc_assertions (
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst_b,
  input wire logic                   i_psel,
  input wire logic                   i_penable,
  input wire logic                   i_sample_vld,
  input wire logic                   i_pwr_ovl,
  input wire adivc_pkg::adivc_meas_t i_den,
  input wire logic [31:0]            o_prdata,
  input wire logic                   o_pready,
  input wire logic                   o_pslverr,
  input wire logic                   o_conv_start,
  input wire logic                   o_thr_out,
  input wire logic                   o_math_err,
  input wire logic                   o_error_out,
  input wire adivc_pkg::adivc_word_t o_quotient
);
  timeunit 1ns;
  timeprecision 1ps;
  import adivc_pkg::*;
  ////////////////////////////////////////////////////////////////
  // Bus phases and common clocking
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_setup; i_psel && !i_penable; endsequence
  sequence s_access; i_psel && i_penable; endsequence
  // Bus answer timing
  property p_rdy_setup; s_setup |=> o_pready; endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("pready late");
  property p_rdy_acc; o_pready |-> s_access; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
  property p_err_rdy; o_pslverr |-> o_pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_rd_idle; !o_pready |-> o_prdata == 32'h00000000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("prdata not idle");
  // Sample pacing and holding
  property p_conv; o_conv_start |=> !o_conv_start; endproperty
  a_conv: assert property (p_conv) else $error("conversion pulse too long");
  property p_q_hold; $changed(o_quotient) |-> $past(i_sample_vld, 2); endproperty
  a_q_hold: assert property (p_q_hold) else $error("quotient moved");
  property p_t_hold;
    $changed(o_thr_out) |-> $past(i_sample_vld, 2) || $past(i_psel) || $past(i_psel, 2);
  endproperty
  a_t_hold: assert property (p_t_hold) else $error("threshold moved");
  // Error paths
  property p_ovl; i_sample_vld && i_pwr_ovl |-> ##2 o_math_err; endproperty
  a_ovl: assert property (p_ovl) else $error("overload not flagged");
  property p_sat;
    i_sample_vld && i_den == 16'h0000 |-> ##2
      (o_quotient == 32'h00000000 || o_quotient == 32'h00030D40);
  endproperty
  a_sat: assert property (p_sat) else $error("quotient not saturated");
  property p_eout; o_error_out |-> o_math_err; endproperty
  a_eout: assert property (p_eout) else $error("error out without cause");
endmodule
bind adivc_top adivc_assertions u_adivc_assertions (.*);

// file: test/adivc_sensor_model.sv
// Sensor pair model delivering one sample per conversion start
// Assumes the bench sets the next readings before the conversion pulse
module adivc_sensor_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_conv_start,
  input  wire logic [15:0] i_num_set,
  input  wire logic [15:0] i_den_set,
  input  wire logic        i_ovl_set,
  output logic      [15:0] o_num = 16'h0000,
  output logic      [15:0] o_den = 16'h0000,
  output logic             o_sample_vld = 1'b0,
  output logic             o_pwr_ovl = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // One reading per conversion, held until the next one
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sample_vld <= 1'b0;
    end else begin
      o_sample_vld <= i_conv_start;
      if (i_conv_start) begin
        o_num     <= i_num_set;
        o_den     <= i_den_set;
        o_pwr_ovl <= i_ovl_set;
      end
    end
  end
endmodule

// file: test/tb_analog_division_comparators.sv
// Bench for the quotient comparators, driven over APB and a sensor model
// Assumes adivc_top with a reduced clock rate parameter
module tb_analog_division_comparators;
  timeunit 1ns;
  timeprecision 1ps;
  import adivc_pkg::*;
  logic        i_sys_clk = 1'b0, i_rst_b = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic        i_pwrite = 1'b0, i_in_ovl = 1'b0, ov_s = 1'b0, err, ws = 1'b0, ts = 1'b0, wa = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [3:0]  i_pstrb = 4'hF;
  logic [31:0] i_pwdata = 32'h0, o_prdata, o_quotient, rd, q, rn, ctl = 32'h0;
  logic [15:0] i_num, i_den, o_analog_num, o_analog_den, n_s = 16'h0, d_s = 16'h0;
  logic        i_sample_vld, i_pwr_ovl, o_pready, o_pslverr, o_conv_start, o_thr_out;
  logic        o_window_in_range_out, o_warn_out, o_math_err, o_error_out;
  int          errors = 0, cmp_count = 0;
  integer      seed = 32'h1AD28F14;
  logic [15:0] cn [12] = '{16'h0191, 16'h0640, 16'h05DC, 16'h05DB, 16'h01F4, 16'h0190,
                           16'h0515, 16'h04B0, 16'h0320, 16'h0321, 16'h02BC, 16'h02BB};
  logic [31:0] cf [8] = '{32'h0, 32'h640, 32'h190, 32'h64, 32'h320, 32'h64, 32'h4B0, 32'h64};
  wire  [15:0] i_num_red = i_num, i_den_red = i_den;
  ////////////////////////////////////////////////////////////////
  // Clock, design and sensor side
  always #10 i_sys_clk = ~i_sys_clk;
  adivc_top #(.CLK_HZ(4000)) u_adivc_top (.*);
  adivc_sensor_model u_adivc_sensor_model (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_conv_start(o_conv_start), .i_num_set(n_s), .i_den_set(d_s), .i_ovl_set(ov_s),
    .o_num(i_num), .o_den(i_den), .o_sample_vld(i_sample_vld), .o_pwr_ovl(i_pwr_ovl));
  ////////////////////////////////////////////////////////////////
  // Compare, bus and sample tasks
  task chk(input logic [31:0] g, input logic [31:0] e, input string s);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, s, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge i_sys_clk);
    i_psel <= 1'b1; i_pwrite <= w; i_paddr <= a; i_pwdata <= dt;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rd = o_prdata; err = o_pslverr; i_psel <= 1'b0; i_penable <= 1'b0;
  endtask
  task samp(input logic [15:0] nn, input logic [15:0] dd, input logic ov);
    n_s <= nn; d_s <= dd; ov_s <= ov;
    do @(posedge i_sys_clk); while (o_conv_start !== 1'b1);
    repeat (3) @(posedge i_sys_clk);
    #1;
    q = (ov || dd == 16'h0) ? (ctl[6] ? 32'h00030D40 : 32'h0) : (32'(nn) << 8) / dd;
    ws = ws ? (q < 32'h640 && q > 32'h1F4) : (q > 32'h190 && q < 32'h5DC);
    ts = ts ? !(q < 32'h2BC) : (q > 32'h320);
    wa = ctl[3] ? (wa ? !(q > 32'h4B0) : (q < 32'h44C)) : (wa ? !(q < 32'h4B0) : (q > 32'h514));
    chk(o_quotient, q, "quotient");
    chk(o_window_in_range_out, ctl[0] & ws, "window");
    chk(o_thr_out, ctl[1] & ~ctl[0] & ts, "threshold");
    chk(o_warn_out, ctl[2] & wa, "warning");
    chk(o_math_err, ov || dd == 16'h0, "math error");
    chk(o_error_out, ctl[8] & (ov || dd == 16'h0), "error out");
    chk(o_analog_num, ctl[7] ? nn : 16'h0, "analog");
    chk(o_analog_den, ctl[7] ? dd : 16'h0, "analog den");
  endtask
  task phase(input logic [31:0] c, input string s);
    ctl = c;
    apb(1'b1, 8'h00, c);
    foreach (cn[i]) samp(cn[i], 16'h0100, 1'b0);
    repeat (40) begin
      rn = $random(seed);
      samp({3'h0, rn[12:0]}, rn[31:29] == 3'h0 ? 16'h0 : 16'h03E8 + rn[27:16], 1'b0);
    end
    $display("test %s done", s);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    apb(1'b0, 8'h24, 32'h0); chk(rd, 32'h0E10, "min reset");
    apb(1'b0, 8'h2C, 32'h0); chk(rd, 32'h2742, "volt reset");
    apb(1'b1, 8'h28, 32'hFFFF); apb(1'b0, 8'h28, 32'h0); chk(rd, 32'h59D8, "max clamp");
    apb(1'b0, 8'h40, 32'h0); chk(err, 1'b1, "unmapped");
    foreach (cf[i]) apb(1'b1, 8'(4 + 4 * i), cf[i]);
    $display("test registers done");
    phase(32'h15, "window");
    phase(32'h116, "threshold");
    ctl = 32'h1DE;
    apb(1'b1, 8'h00, ctl);
    samp(16'h01F4, 16'h0000, 1'b0);
    samp(16'h01F4, 16'h0100, 1'b1);
    samp(16'h01F4, 16'h0100, 1'b0);
    $display("test errors done");
    finish_test;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    errors++;
    finish_test;
  end
endmodule
